// [shared/sat_params.svh]
// register offsets, field positions, reset values and code values for sub-audio signalling
`ifndef SAT_PARAMS_SVH
`define SAT_PARAMS_SVH
// ************************
// register offsets
// ************************
`define SAT_MOD_GAIN_OFS 8'hb0
`define SAT_MODE_CTRL_OFS 8'hc1
`define SAT_AUDIO_CTRL_OFS 8'hc2
`define SAT_STATUS_OFS 8'hc6
`define SAT_PROG_OFS 8'hc8
`define SAT_TONE_RPT_OFS 8'hcc
// ************************
// field positions
// ************************
`define SAT_MODE_CTCSS_EN 0
`define SAT_MODE_DCS_EN 1
`define SAT_MODE_TX 2
`define SAT_MODE_CTCSS_IRQ 3
`define SAT_MODE_DCS_IRQ 4
`define SAT_MODE_DCS_LEN24 5
`define SAT_AUD_PHASE 8
`define SAT_AUD_HPF 9
`define SAT_GAIN_INV1 0
`define SAT_GAIN_INV2 1
`define SAT_STAT_CTCSS 11
`define SAT_STAT_DCS 10
`define SAT_RPT_PHASE 9
// ************************
// reset values and code values
// ************************
`define SAT_CODE_RST 8'h00
`define SAT_BW_RST 12'h000
`define SAT_USER_FREQ_RST 12'h000
`define SAT_CODE_LEARN 8'hc8
`define SAT_CODE_ALLCALL 8'hf0
`define SAT_CODE_USER 8'hfc
`define SAT_CODE_OFF 8'hfe
`define SAT_CODE_INVALID 8'hff
`define SAT_CODE_DCS_USER 8'h54
`define SAT_CODE_DCS_INV 8'h64
`define SAT_TONE_ALLCALL 6'h28
`define SAT_TONE_OFF 6'h36
`define SAT_LEARN_MAX 6'h27
`define SAT_MAX_ERRS 5'h03
`endif

// [shared/sat_pkg.sv]
// types shared by the sub-audio signalling block
package sat_pkg;
  typedef logic [15:0] sat_word_t; // register data word
  typedef logic [7:0] sat_code_t; // sub-audio code value
  typedef logic [11:0] sat_freq_t; // tone frequency in 0.1 hz units
  // which receive detector owns the sub-audio band
  typedef enum logic [1:0] {SAT_DET_OFF, SAT_DET_CTCSS, SAT_DET_DCS} sat_det_t;
endpackage

// [shared/sat_rom_if.sv]
// carrier between the control logic and the tone frequency table
interface sat_rom_if;
  logic [7:0] idx; // code value looked up
  logic [11:0] freq; // registered frequency, 0.1 hz units
  modport user (output idx, input freq);
  modport rom (input idx, output freq);
endinterface

// [logic/sat_tone_rom.sv]
// fixed ctcss tone frequency table with registered read data
module sat_tone_rom (
  input wire logic clk,
  input wire logic reset_n,
  sat_rom_if.rom rom
);
  import sat_pkg::*;

  // ************************
  // table lookup, one cycle latency
  // ************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rom.freq <= 12'h000;
    end else begin
      case (rom.idx)
        8'd201: rom.freq <= 12'd670;
        8'd202: rom.freq <= 12'd719;
        8'd203: rom.freq <= 12'd744;
        8'd204: rom.freq <= 12'd770;
        8'd205: rom.freq <= 12'd797;
        8'd206: rom.freq <= 12'd825;
        8'd207: rom.freq <= 12'd854;
        8'd208: rom.freq <= 12'd885;
        8'd209: rom.freq <= 12'd915;
        8'd210: rom.freq <= 12'd948;
        8'd211: rom.freq <= 12'd974;
        8'd212: rom.freq <= 12'd1000;
        8'd213: rom.freq <= 12'd1035;
        8'd214: rom.freq <= 12'd1072;
        8'd215: rom.freq <= 12'd1109;
        8'd216: rom.freq <= 12'd1148;
        8'd217: rom.freq <= 12'd1188;
        8'd218: rom.freq <= 12'd1230;
        8'd219: rom.freq <= 12'd1273;
        8'd220: rom.freq <= 12'd1318;
        8'd221: rom.freq <= 12'd1365;
        8'd222: rom.freq <= 12'd1413;
        8'd223: rom.freq <= 12'd1462;
        8'd224: rom.freq <= 12'd1514;
        8'd225: rom.freq <= 12'd1567;
        8'd226: rom.freq <= 12'd1622;
        8'd227: rom.freq <= 12'd1679;
        8'd228: rom.freq <= 12'd1738;
        8'd229: rom.freq <= 12'd1799;
        8'd230: rom.freq <= 12'd1862;
        8'd231: rom.freq <= 12'd1928;
        8'd232: rom.freq <= 12'd2035;
        8'd233: rom.freq <= 12'd2107;
        8'd234: rom.freq <= 12'd2181;
        8'd235: rom.freq <= 12'd2257;
        8'd236: rom.freq <= 12'd2336;
        8'd237: rom.freq <= 12'd2418;
        8'd238: rom.freq <= 12'd2503;
        8'd239: rom.freq <= 12'd693;
        8'd240: rom.freq <= 12'd625;
        8'd241: rom.freq <= 12'd1598;
        8'd242: rom.freq <= 12'd1655;
        8'd243: rom.freq <= 12'd1713;
        8'd244: rom.freq <= 12'd1773;
        8'd245: rom.freq <= 12'd1835;
        8'd246: rom.freq <= 12'd1899;
        8'd247: rom.freq <= 12'd1966;
        8'd248: rom.freq <= 12'd1995;
        8'd249: rom.freq <= 12'd2065;
        8'd250: rom.freq <= 12'd2291;
        8'd251: rom.freq <= 12'd2541;
        8'd253: rom.freq <= 12'd647;
        8'd254: rom.freq <= 12'd1344;
        default: rom.freq <= 12'h000; // no fixed tone for this code
      endcase
    end
  end
endmodule

// [logic/sat_top.sv]
// sub-audio signalling control: code select, ctcss/dcs reporting, learning mode
`include "sat_params.svh"
module sat_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr,
  input wire sat_pkg::sat_word_t reg_wdata,
  output sat_pkg::sat_word_t reg_rdata,
  input wire logic det_valid, // tone detector result strobe
  input wire logic [5:0] det_tone, // detected tone number, 0 none, 55 unlisted
  input wire logic det_phase, // phase step of 90 degrees or more
  input wire logic dcs_bit_valid, // sliced dcs bit strobe
  input wire logic dcs_bit,
  input wire logic [23:0] dcs_table_word, // code word of the selected table code
  output logic ctcss_irq_event,
  output logic dcs_irq_event,
  output logic tx_tone_on,
  output sat_pkg::sat_freq_t tx_tone_freq,
  output logic dcs_tx_on,
  output logic [23:0] dcs_tx_word,
  output logic dcs_tx_invert,
  output logic mod_one_invert,
  output logic mod_two_invert,
  output logic tx_phase_change,
  output logic audio_highpass_filter,
  output logic [11:0] tone_decoder_bandwidth_threshold,
  output logic ctcss_rx_active,
  output logic dcs_rx_active
);
  import sat_pkg::*;

  // ************************
  // helpers
  // ************************
  // count of set bits, used for both dcs polarities
  function automatic logic [4:0] ones(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 24; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // true for codes that name a ctcss tone the generator can send
  function automatic logic is_tx_tone(input sat_code_t c);
    return (c > `SAT_CODE_LEARN) && (c < `SAT_CODE_INVALID);
  endfunction

  // ************************
  // registers
  // ************************
  logic [15:0] mode_ff; // mode control
  logic [15:0] audio_ff; // audio control, low byte is the code
  logic [1:0] gain_ff; // modulator output inversion bits
  logic [11:0] bw_ff; // decoder bandwidth and threshold
  logic [11:0] user_freq_ff; // user tone frequency
  logic [23:0] user_dcs_ff; // user dcs code word
  sat_code_t code;
  logic ctcss_en, dcs_en, tx_mode;

  assign code = audio_ff[7:0];
  assign ctcss_en = mode_ff[`SAT_MODE_CTCSS_EN];
  assign dcs_en = mode_ff[`SAT_MODE_DCS_EN];
  assign tx_mode = mode_ff[`SAT_MODE_TX];

  // write side; each register only changes on its own offset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_ff <= 16'h0000;
      audio_ff <= {8'h00, `SAT_CODE_RST};
      gain_ff <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `SAT_MODE_CTRL_OFS: mode_ff <= reg_wdata; // code untouched
        `SAT_AUDIO_CTRL_OFS: audio_ff <= reg_wdata;
        `SAT_MOD_GAIN_OFS: gain_ff <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // program settings: top nibble picks the entry, low 12 bits the value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bw_ff <= `SAT_BW_RST;
      user_freq_ff <= `SAT_USER_FREQ_RST;
      user_dcs_ff <= 24'h000000;
    end else if (reg_wr && reg_addr == `SAT_PROG_OFS) begin
      case (reg_wdata[15:12])
        4'h0: bw_ff <= reg_wdata[11:0];
        4'h1: user_freq_ff <= reg_wdata[11:0];
        4'h2: user_dcs_ff[11:0] <= reg_wdata[11:0];
        4'h3: user_dcs_ff[23:12] <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  // ************************
  // detector ownership
  // ************************
  sat_det_t det_sel;
  // ctcss wins when both are enabled; neither listens while sending
  always_comb begin
    if (tx_mode) det_sel = SAT_DET_OFF;
    else if (ctcss_en) det_sel = SAT_DET_CTCSS;
    else if (dcs_en) det_sel = SAT_DET_DCS;
    else det_sel = SAT_DET_OFF;
  end

  logic ctcss_act, dcs_act;
  assign ctcss_act = (det_sel == SAT_DET_CTCSS);
  assign dcs_act = (det_sel == SAT_DET_DCS);

  // ************************
  // ctcss classification
  // ************************
  sat_code_t ctcss_val; // value the detector result would report
  logic own_hit;
  always_comb begin
    ctcss_val = 8'h00;
    own_hit = (det_tone == `SAT_TONE_ALLCALL) && (code == `SAT_CODE_ALLCALL); // all-call can be own tone
    if (det_tone == 6'h00) begin
      ctcss_val = 8'h00; // nothing heard
    end else if (det_tone == `SAT_TONE_ALLCALL) begin
      ctcss_val = `SAT_CODE_ALLCALL;
    end else if (code == `SAT_CODE_RST) begin
      ctcss_val = 8'h00; // only all-call is scanned
    end else if (code == `SAT_CODE_LEARN) begin
      if (det_tone <= `SAT_LEARN_MAX) begin
        ctcss_val = `SAT_CODE_LEARN + {2'h0, det_tone};
        own_hit = 1'b1;
      end else begin
        ctcss_val = `SAT_CODE_INVALID;
      end
    end else if (code > `SAT_CODE_LEARN && code != `SAT_CODE_INVALID && det_tone == 6'(code - `SAT_CODE_LEARN)) begin
      ctcss_val = code;
      own_hit = 1'b1;
    end else begin
      ctcss_val = `SAT_CODE_INVALID;
    end
  end

  // ************************
  // dcs matching
  // ************************
  logic [23:0] dcs_sh_ff; // last received bits, newest at the top
  logic [1:0] dcs_cnt_ff; // bit count within a group of four
  logic dcs_eval_ff; // one cycle after a fourth bit
  logic dcs_seen_ff; // a valid code was seen
  logic dcs_valid_ff;
  logic [23:0] dcs_word, dcs_mask, dcs_rx;
  logic dcs_inv_code, dcs_code_ok;
  logic [4:0] err_true, err_inv;

  assign dcs_inv_code = (code > `SAT_CODE_DCS_INV);
  assign dcs_code_ok = (code != 8'h00) && (code <= `SAT_CODE_DCS_INV + `SAT_CODE_DCS_USER);
  assign dcs_word = (code == `SAT_CODE_DCS_USER || code == `SAT_CODE_DCS_INV + `SAT_CODE_DCS_USER) ?
                    user_dcs_ff : dcs_table_word;
  assign dcs_mask = mode_ff[`SAT_MODE_DCS_LEN24] ? 24'hffffff : 24'h7fffff;
  // a 23 bit code sits in the top 23 bits of the shift register
  assign dcs_rx = mode_ff[`SAT_MODE_DCS_LEN24] ? dcs_sh_ff : {1'b0, dcs_sh_ff[23:1]};
  assign err_true = ones((dcs_rx ^ dcs_word) & dcs_mask);
  assign err_inv = ones((dcs_rx ^ ~dcs_word) & dcs_mask);

  // shift bits in least significant first
  always_ff @(posedge clk) begin
    if (!reset_n || !dcs_act) begin
      dcs_sh_ff <= 24'h000000;
      dcs_cnt_ff <= 2'h0;
      dcs_eval_ff <= 1'b0;
    end else begin
      dcs_eval_ff <= dcs_bit_valid && dcs_cnt_ff == 2'h3;
      if (dcs_bit_valid) begin
        dcs_sh_ff <= {dcs_bit, dcs_sh_ff[23:1]};
        dcs_cnt_ff <= dcs_cnt_ff + 2'h1;
      end
    end
  end

  // match verdict refreshed once per four bits
  logic dcs_match;
  assign dcs_match = dcs_code_ok && ((dcs_inv_code ? err_inv : err_true) <= `SAT_MAX_ERRS);
  always_ff @(posedge clk) begin
    if (!reset_n || !dcs_act) begin
      dcs_valid_ff <= 1'b0;
    end else if (dcs_eval_ff) begin
      dcs_valid_ff <= dcs_match;
    end
  end

  // ************************
  // tone report and events
  // ************************
  sat_code_t rpt_ff; // reported tone value
  logic phase_ff; // phase reversal seen
  logic ctcss_valid_ff;
  logic rpt_rd;
  logic turnoff;

  assign rpt_rd = reg_rd && reg_addr == `SAT_TONE_RPT_OFS;
  assign turnoff = dcs_act && dcs_seen_ff && det_valid && det_tone == `SAT_TONE_OFF;

  // report only moves when the detected state moves, so reads stay stable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rpt_ff <= 8'h00;
      ctcss_valid_ff <= 1'b0;
      ctcss_irq_event <= 1'b0;
    end else begin
      ctcss_irq_event <= 1'b0;
      if (ctcss_act && det_valid) begin
        rpt_ff <= ctcss_val;
        ctcss_valid_ff <= own_hit || det_phase || phase_ff;
        // to or from no tone, or leaving own tone
        if (ctcss_val != rpt_ff && (rpt_ff == 8'h00 || ctcss_val == 8'h00 || rpt_ff == code)) begin
          ctcss_irq_event <= mode_ff[`SAT_MODE_CTCSS_IRQ];
        end
      end else if (turnoff) begin
        rpt_ff <= `SAT_CODE_OFF;
      end else if (dcs_eval_ff && dcs_match) begin
        rpt_ff <= code; // received form of the code
      end else if (!ctcss_act) begin
        ctcss_valid_ff <= 1'b0;
      end
    end
  end

  // phase flag: a new reversal wins over a read that clears it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= 1'b0;
    end else if (ctcss_act && det_valid && det_phase) begin
      phase_ff <= 1'b1;
    end else if (rpt_rd) begin
      phase_ff <= 1'b0;
    end
  end

  // turn-off tone only counts once a code has been recognised
  always_ff @(posedge clk) begin
    if (!reset_n || !dcs_act) begin
      dcs_seen_ff <= 1'b0;
      dcs_irq_event <= 1'b0;
    end else begin
      dcs_irq_event <= turnoff && mode_ff[`SAT_MODE_DCS_IRQ];
      if (turnoff) dcs_seen_ff <= 1'b0;
      else if (dcs_eval_ff && dcs_match) dcs_seen_ff <= 1'b1;
    end
  end

  // ************************
  // read side
  // ************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SAT_STATUS_OFS: reg_rdata <= {4'h0, ctcss_valid_ff, dcs_valid_ff, 10'h000};
        `SAT_TONE_RPT_OFS: reg_rdata <= {6'h00, phase_ff, 1'b0, rpt_ff};
        default: reg_rdata <= 16'h0000; // write-only and unmapped read zero
      endcase
    end
  end

  // ************************
  // transmit side and static outputs
  // ************************
  sat_rom_if rom_bus ();
  assign rom_bus.idx = code;
  sat_tone_rom u_rom (
    .clk(clk),
    .reset_n(reset_n),
    .rom(rom_bus.rom)
  );

  // learning, code 0 and invalid leave the generator silent
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_tone_on <= 1'b0;
      tx_tone_freq <= 12'h000;
      dcs_tx_on <= 1'b0;
      dcs_tx_word <= 24'h000000;
      dcs_tx_invert <= 1'b0;
    end else begin
      tx_tone_on <= ctcss_en && tx_mode && is_tx_tone(code);
      tx_tone_freq <= (code == `SAT_CODE_USER) ? user_freq_ff : rom_bus.freq;
      dcs_tx_on <= dcs_en && !ctcss_en && tx_mode && dcs_code_ok;
      dcs_tx_word <= dcs_word & dcs_mask;
      dcs_tx_invert <= dcs_inv_code;
    end
  end

  // control bits passed to the audio and modulator paths
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mod_one_invert <= 1'b0;
      mod_two_invert <= 1'b0;
      tx_phase_change <= 1'b0;
      audio_highpass_filter <= 1'b0;
      tone_decoder_bandwidth_threshold <= `SAT_BW_RST;
      ctcss_rx_active <= 1'b0;
      dcs_rx_active <= 1'b0;
    end else begin
      mod_one_invert <= gain_ff[`SAT_GAIN_INV1];
      mod_two_invert <= gain_ff[`SAT_GAIN_INV2];
      tx_phase_change <= audio_ff[`SAT_AUD_PHASE];
      audio_highpass_filter <= audio_ff[`SAT_AUD_HPF];
      tone_decoder_bandwidth_threshold <= bw_ff;
      ctcss_rx_active <= ctcss_act;
      dcs_rx_active <= dcs_act;
    end
  end

  // ************************
  // assertions
  // ************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_allcall_arrives;
    ctcss_act && det_valid && det_tone == `SAT_TONE_ALLCALL && rpt_ff == 8'h00 && mode_ff[`SAT_MODE_CTCSS_IRQ];
  endsequence

  property p_code_kept;
    reg_wr && reg_addr == `SAT_MODE_CTRL_OFS |=> code == $past(code);
  endproperty
  a_code_kept: assert property (p_code_kept) else $error("mode write changed code");

  property p_own_valid;
    ctcss_act && det_valid && code > `SAT_CODE_LEARN && code < `SAT_CODE_USER
      && det_tone == 6'(code - `SAT_CODE_LEARN) |=> ctcss_valid_ff && rpt_ff == $past(code);
  endproperty
  a_own_valid: assert property (p_own_valid) else $error("own tone not flagged");

  property p_phase;
    ctcss_act && det_valid && det_phase |=> phase_ff && ctcss_valid_ff;
  endproperty
  a_phase: assert property (p_phase) else $error("phase reversal not flagged");

  property p_learn;
    ctcss_act && det_valid && code == `SAT_CODE_LEARN && det_tone != 6'h00 && det_tone <= `SAT_LEARN_MAX
      |=> rpt_ff == `SAT_CODE_LEARN + {2'h0, $past(det_tone)};
  endproperty
  a_learn: assert property (p_learn) else $error("learned tone misreported");

  property p_allcall;
    ctcss_act && det_valid && det_tone == `SAT_TONE_ALLCALL |=> rpt_ff == `SAT_CODE_ALLCALL;
  endproperty
  a_allcall: assert property (p_allcall) else $error("all-call not reported");

  property p_other;
    ctcss_act && det_valid && code > `SAT_CODE_LEARN && det_tone != 6'h00 && det_tone != `SAT_TONE_ALLCALL
      && det_tone != 6'(code - `SAT_CODE_LEARN) |=> rpt_ff == `SAT_CODE_INVALID;
  endproperty
  a_other: assert property (p_other) else $error("other tone not 255");

  property p_irq_in;
    s_allcall_arrives |=> ctcss_irq_event ##1 (!ctcss_irq_event || $past(det_valid));
  endproperty
  a_irq_in: assert property (p_irq_in) else $error("no event on tone arrival");

  property p_tx_silent;
    (tx_mode && (code == `SAT_CODE_LEARN || code == 8'h00)) [*2] |-> !tx_tone_on;
  endproperty
  a_tx_silent: assert property (p_tx_silent) else $error("generator on for silent code");

  property p_one_detector;
    !(ctcss_rx_active && dcs_rx_active);
  endproperty
  a_one_detector: assert property (p_one_detector) else $error("two detectors active");

  property p_dcs_cadence;
    $changed(dcs_valid_ff) && $past(dcs_act) && dcs_act |-> $past(dcs_eval_ff);
  endproperty
  a_dcs_cadence: assert property (p_dcs_cadence) else $error("dcs flag off cadence");
endmodule

// [bench/sat_radio_model.sv]
// behavioural far side: demodulated sub-audio tone and dcs bit source
module sat_radio_model (
  input wire logic clk,
  output logic det_valid,
  output logic [5:0] det_tone,
  output logic det_phase,
  output logic dcs_bit_valid,
  output logic dcs_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************
  // idle state
  // ************************
  initial begin
    det_valid = 1'b0;
    det_tone = 6'h00;
    det_phase = 1'b0;
    dcs_bit_valid = 1'b0;
    dcs_bit = 1'b0;
  end
  // one detector result; lines show the inverse once the strobe drops, never the held value
  task automatic tone(input logic [5:0] t, input logic ph);
    @(posedge clk);
    det_valid <= 1'b1;
    det_tone <= t;
    det_phase <= ph;
    @(posedge clk);
    det_valid <= 1'b0;
    det_tone <= ~t;
    det_phase <= ~ph;
    repeat (3) @(posedge clk);
  endtask
  // dcs bits, least significant first, one idle cycle between strobes
  task automatic dcs_send(input logic [23:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      dcs_bit_valid <= 1'b1;
      dcs_bit <= w[i];
      @(posedge clk);
      dcs_bit_valid <= 1'b0;
      dcs_bit <= ~w[i];
    end
    repeat (4) @(posedge clk);
  endtask
endmodule

// [bench/sat_top_tb.sv]
// self-checking bench for the sub-audio signalling block
`include "sat_params.svh"
module sat_top_tb;
  import sat_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, reg_wr, reg_rd, det_valid, det_phase, dcs_bit_valid, dcs_bit;
  logic [7:0] reg_addr;
  sat_word_t reg_wdata, reg_rdata, rd;
  logic [5:0] det_tone;
  logic [23:0] dcs_table_word, dcs_tx_word;
  logic ctcss_irq_event, dcs_irq_event, tx_tone_on, dcs_tx_on, dcs_tx_invert, mod_one_invert, mod_two_invert;
  logic tx_phase_change, audio_highpass_filter, ctcss_rx_active, dcs_rx_active;
  sat_freq_t tx_tone_freq;
  logic [11:0] tone_decoder_bandwidth_threshold;
  int mismatches = 0, num_checks = 0, irq_seen = 0, dcs_irq_seen = 0;
  // ************************
  // clock, design and far side
  // ************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sat_top i_dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .det_valid(det_valid), .det_tone(det_tone),
    .det_phase(det_phase), .dcs_bit_valid(dcs_bit_valid), .dcs_bit(dcs_bit), .dcs_table_word(dcs_table_word),
    .ctcss_irq_event(ctcss_irq_event), .dcs_irq_event(dcs_irq_event), .tx_tone_on(tx_tone_on),
    .tx_tone_freq(tx_tone_freq), .dcs_tx_on(dcs_tx_on), .dcs_tx_word(dcs_tx_word), .dcs_tx_invert(dcs_tx_invert),
    .mod_one_invert(mod_one_invert), .mod_two_invert(mod_two_invert), .tx_phase_change(tx_phase_change),
    .audio_highpass_filter(audio_highpass_filter),
    .tone_decoder_bandwidth_threshold(tone_decoder_bandwidth_threshold),
    .ctcss_rx_active(ctcss_rx_active), .dcs_rx_active(dcs_rx_active));
  sat_radio_model i_radio (.clk(clk), .det_valid(det_valid), .det_tone(det_tone), .det_phase(det_phase),
    .dcs_bit_valid(dcs_bit_valid), .dcs_bit(dcs_bit));
  // event pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (ctcss_irq_event === 1'b1) irq_seen <= irq_seen + 1;
    if (dcs_irq_event === 1'b1) dcs_irq_seen <= dcs_irq_seen + 1;
  end
  // ************************
  // access tasks
  // ************************
  task automatic check(input string what, input sat_word_t exp, input sat_word_t got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write taken at the edge that sees the strobe, effect one cycle later
  task automatic reg_write(input logic [7:0] a, input sat_word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // read data is registered and holds, so sample it one edge later
  task automatic reg_read(input logic [7:0] a, output sat_word_t d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask
  // tone result then report read, the common pair of most scenarios
  task automatic tone_report(input logic [5:0] t, input logic ph, input sat_word_t exp);
    i_radio.tone(t, ph);
    reg_read(`SAT_TONE_RPT_OFS, rd);
    check("tone report", exp, rd);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ************************
  // watchdog
  // ************************
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
  // ************************
  // tests
  // ************************
  initial begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
    dcs_table_word = {1'b0, 11'h763, 12'h813};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // host wiring: inverted outputs, phase control, highpass, narrow bandwidth
    reg_write(`SAT_MOD_GAIN_OFS, 16'h0003);
    reg_write(`SAT_PROG_OFS, 16'h0012);
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h03c9);
    check("mod outputs", 16'h0003, {14'h0, mod_two_invert, mod_one_invert});
    check("phase and filter", 16'h0003, {14'h0, audio_highpass_filter, tx_phase_change});
    check("bandwidth", 16'h0012, {4'h0, tone_decoder_bandwidth_threshold});
    reg_read(8'h55, rd);
    check("unmapped read", 16'h0000, rd);
    $display("test registers done");
    // ctcss receive of own tone, all-call, stranger, silence
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0009);
    tone_report(6'd1, 1'b0, 16'h00c9);
    reg_read(`SAT_STATUS_OFS, rd);
    check("own tone status", 16'h0800, rd & 16'h0800);
    tone_report(6'd40, 1'b0, 16'h00f0);
    tone_report(6'd7, 1'b0, 16'h00ff);
    tone_report(6'd0, 1'b0, 16'h0000);
    check("ctcss events", 16'd3, 16'(irq_seen));
    $display("test ctcss receive done");
    // phase reversal flag, cleared by the report read
    tone_report(6'd7, 1'b1, 16'h02ff);
    reg_read(`SAT_STATUS_OFS, rd);
    check("phase status", 16'h0800, rd & 16'h0800);
    reg_read(`SAT_TONE_RPT_OFS, rd);
    check("phase cleared", 16'h00ff, rd);
    // enable off and on again keeps the code
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0000);
    check("rx off", 16'h0000, {15'h0, ctcss_rx_active});
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0009);
    tone_report(6'd2, 1'b0, 16'h00ff);
    tone_report(6'd1, 1'b0, 16'h00c9);
    $display("test phase and enable done");
    // learning mode and code zero
    reg_write(`SAT_AUDIO_CTRL_OFS, {8'h00, `SAT_CODE_LEARN});
    tone_report(6'd5, 1'b0, 16'h00cd);
    tone_report(6'd39, 1'b0, 16'h00ef);
    tone_report(6'd41, 1'b0, 16'h00ff);
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0005);
    repeat (3) @(posedge clk);
    check("learn tx silent", 16'h0000, {15'h0, tx_tone_on});
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0001);
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h0000);
    tone_report(6'd40, 1'b0, 16'h00f0);
    tone_report(6'd5, 1'b0, 16'h0000);
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0005);
    repeat (3) @(posedge clk);
    check("code zero tx", 16'h0000, {15'h0, tx_tone_on});
    $display("test learning done");
    // transmit tones: fixed table entry and user frequency
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h00c9);
    repeat (3) @(posedge clk);
    check("tx on", 16'h0001, {15'h0, tx_tone_on});
    check("tx freq", 16'h029e, {4'h0, tx_tone_freq});
    reg_write(`SAT_PROG_OFS, 16'h1456);
    reg_write(`SAT_AUDIO_CTRL_OFS, {8'h00, `SAT_CODE_USER});
    repeat (3) @(posedge clk);
    check("user freq", 16'h0456, {4'h0, tx_tone_freq});
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h00fd);
    repeat (3) @(posedge clk);
    check("extended freq", 16'h0287, {4'h0, tx_tone_freq});
    $display("test transmit done");
    // one detector only, then dcs match and turn-off
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h0001);
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0003);
    check("one detector", 16'h0001, {14'h0, dcs_rx_active, ctcss_rx_active});
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0012);
    i_radio.dcs_send({1'b0, dcs_table_word[22], 22'h0}, 1);
    i_radio.dcs_send(dcs_table_word, 23);
    reg_read(`SAT_STATUS_OFS, rd);
    check("dcs match", 16'h0400, rd & 16'h0400);
    reg_read(`SAT_TONE_RPT_OFS, rd);
    check("dcs code report", 16'h0001, rd);
    tone_report(6'd54, 1'b0, 16'h00fe);
    check("dcs event", 16'd1, 16'(dcs_irq_seen));
    i_radio.dcs_send(~dcs_table_word, 24);
    reg_read(`SAT_STATUS_OFS, rd);
    check("dcs fail", 16'h0000, rd & 16'h0400);
    // inverted code 1 sent as a 24 bit word
    reg_write(`SAT_AUDIO_CTRL_OFS, 16'h0065);
    reg_write(`SAT_MODE_CTRL_OFS, 16'h0026);
    repeat (2) @(posedge clk);
    check("dcs tx flags", 16'h0003, {14'h0, dcs_tx_on, dcs_tx_invert});
    check("dcs tx low", 16'h3813, dcs_tx_word[15:0]);
    check("dcs tx high", 16'h0076, {8'h00, dcs_tx_word[23:16]});
    $display("test dcs done");
    tally_and_finish();
  end
endmodule
